//--- dv/code_memory_model.sv
// behavioural code memory array facing the code access engine
// assumes: strobes, address and write data come from the design
`timescale 1ns/1ps
module code_memory_model (
   // clock
   input wire logic sys_clk,
   // code memory port
   input wire logic [15:0] code_addr,
   input wire logic code_rd,
   input wire logic code_wr,
   input wire logic [7:0] code_wdata,
   output logic [7:0] code_rdata
);
   logic [7:0] mem [65536];
   logic [2:0] rd_cnt_q = 3'h0;
   logic [7:0] last_q = 8'h00;

   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = i[7:0] ^ i[15:8];
      end
   end

   // slow part: data settles only on the fourth read clock; before that
   // and when idle the bus toggles, so an early sample is caught
   assign code_rdata = (code_rd && rd_cnt_q == 3'h3) ? mem[code_addr] : ~last_q;

   always @(posedge sys_clk) begin
      last_q <= code_rdata;
      rd_cnt_q <= !code_rd ? 3'h0 : (rd_cnt_q == 3'h3) ? 3'h3 : rd_cnt_q + 3'h1;
      if (code_wr) begin
         mem[code_addr] <= code_wdata;
      end
   end
endmodule

//--- dv/imem_checker.sv
// port-level checks for the data space decoder and code access timing
// assumes: bound to the top module, a single clock domain
`timescale 1ns/1ps
module imem_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // data space
   input wire logic mem_req,
   input wire imem_pkg::access_kind_t mem_kind,
   input wire logic [7:0] mem_addr,
   input wire logic mem_ack,
   input wire imem_pkg::region_t mem_region,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   // code memory
   input wire logic [15:0] code_addr,
   input wire logic code_rd,
   input wire logic code_wr,
   input wire logic [7:0] code_wdata,
   // external move
   input wire logic xmove_via_pointer,
   input wire logic [15:0] data_pointer,
   input wire logic [7:0] xmove_reg,
   input wire logic [7:0] port_two_page,
   input wire logic [7:0] accumulator,
   input wire logic [2:0] data_wait_control,
   // status
   input wire logic program_write_enable,
   input wire logic [2:0] code_wait_select
);
   logic [3:0] rd_len_q;
   logic [3:0] rd_len_d;
   logic [3:0] wr_len_q;
   logic [3:0] wr_len_d;
   logic [3:0] rd_exp;
   logic dir;
   logic loc;

   assign dir = mem_req && mem_kind == imem_pkg::KIND_DIRECT;
   assign loc = mem_addr == 8'h87 || mem_addr == 8'h92;
   // waits below three are stretched to three
   assign rd_exp = (code_wait_select < 3'h3) ? 4'h4 : code_wait_select + 4'h1;

   always_comb begin
      rd_len_d = code_rd ? rd_len_q + 4'h1 : 4'h0;
      wr_len_d = code_wr ? wr_len_q + 4'h1 : 4'h0;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_len_q <= 4'h0;
         wr_len_q <= 4'h0;
      end else begin
         rd_len_q <= rd_len_d;
         wr_len_q <= wr_len_d;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd_start; $rose(code_rd); endsequence
   sequence s_rd_min; code_rd [*4]; endsequence

   property p_ack; mem_req |=> mem_ack; endproperty
   a_ack: assert property (p_ack) else $error("no ack after access");
   property p_bank; dir && mem_addr <= 8'h1F |=> mem_region == imem_pkg::REGION_BANK; endproperty
   a_bank: assert property (p_bank) else $error("bank region");
   property p_bit_area; mem_req && mem_kind == imem_pkg::KIND_BIT && !mem_addr[7]
      |=> mem_region == imem_pkg::REGION_BIT_AREA; endproperty
   a_bit_area: assert property (p_bit_area) else $error("bit area");
   property p_upper; mem_req && mem_kind == imem_pkg::KIND_INDIRECT && mem_addr[7]
      |-> !sfr_rd ##1 mem_region == imem_pkg::REGION_UPPER_RAM; endproperty
   a_upper: assert property (p_upper) else $error("upper ram");
   property p_sfr; dir && mem_addr[7] |-> (loc || (sfr_rd && sfr_addr == mem_addr))
      ##1 mem_region == imem_pkg::REGION_SFR; endproperty
   a_sfr: assert property (p_sfr) else $error("register route");
   property p_bit_sfr; mem_req && mem_kind == imem_pkg::KIND_BIT && mem_addr[7]
      |-> sfr_addr == {mem_addr[7:3], 3'h0}; endproperty
   a_bit_sfr: assert property (p_bit_sfr) else $error("bit byte");
   property p_rd_min; s_rd_start |-> s_rd_min; endproperty
   a_rd_min: assert property (p_rd_min) else $error("read too short");
   property p_rd_len; $fell(code_rd) |-> rd_len_q == rd_exp; endproperty
   a_rd_len: assert property (p_rd_len) else $error("read length");
   property p_rd_hold; code_rd && $past(code_rd) |-> $stable(code_addr); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read address moved");
   property p_wr_len; $fell(code_wr) |-> wr_len_q == data_wait_control + 4'h1; endproperty
   a_wr_len: assert property (p_wr_len) else $error("write length");
   property p_wr_gate; code_wr |-> program_write_enable; endproperty
   a_wr_gate: assert property (p_wr_gate) else $error("write not enabled");
   property p_wr_src; code_wr |-> code_wdata == accumulator && code_addr ==
      (xmove_via_pointer ? data_pointer : {port_two_page, xmove_reg}); endproperty
   a_wr_src: assert property (p_wr_src) else $error("write source");
   property p_reset; $rose(rst_n) |-> code_wait_select == 3'h7 && !program_write_enable;
   endproperty
   a_reset: assert property (p_reset) else $error("reset values");
endmodule

bind internal_memory_and_code_access imem_checker i_chk (.*);

//--- dv/testbench.sv
// self-checking bench: data space decode, local registers, code access
// assumes: design and package compiled first, code memory model beside
`timescale 1ns/1ps
module testbench;
   logic sys_clk, rst_n, mem_req, mem_wr, mem_ack, fetch_req, fetch_done;
   logic sfr_rd, sfr_wr, xmove_req, xmove_wr, xmove_via_pointer, xmove_done;
   logic xdata_rd, xdata_wr, code_rd, code_wr, program_write_enable;
   logic s_rd, s_wr;
   logic [1:0] mem_bank;
   logic [2:0] data_wait_control, code_wait_select;
   logic [7:0] mem_addr, mem_wdata, mem_rdata, sfr_addr, sfr_wdata, sfr_rdata;
   logic [7:0] fetch_data, xmove_reg, port_two_page, accumulator, xdata_wdata;
   logic [7:0] code_wdata, code_rdata, rd_q, s_a, s_wd;
   logic [15:0] fetch_addr, data_pointer, xdata_addr, code_addr;
   imem_pkg::access_kind_t mem_kind;
   imem_pkg::region_t mem_region;
   int err_count = 0;
   int compares = 0;

   internal_memory_and_code_access i_dut (.*);
   code_memory_model i_mem (.*);
   // outside registers answer with a pattern of their address
   assign sfr_rdata = sfr_addr ^ 8'h5A;

   // ---------------------------------------------------------------
   // compare and bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input imem_pkg::region_t got, input imem_pkg::region_t exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t region %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input imem_pkg::access_kind_t k,
         input logic [7:0] a, input logic [7:0] wd);
      @(posedge sys_clk);
      mem_req <= 1'b1;
      mem_wr <= wr;
      mem_kind <= k;
      mem_addr <= a;
      mem_wdata <= wd;
      #1 {s_rd, s_wr, s_a, s_wd} = {sfr_rd, sfr_wr, sfr_addr, sfr_wdata};
      @(posedge sys_clk);
      mem_req <= 1'b0;
      #1 chk(mem_ack, 1'b1);
      rd_q = mem_rdata;
   endtask
   task automatic fetch(input logic [15:0] a, input logic [7:0] d, input int n);
      int c;
      @(posedge sys_clk);
      fetch_req <= 1'b1;
      fetch_addr <= a;
      c = 0;
      do begin
         @(posedge sys_clk);
         #1 c++;
      end while (fetch_done !== 1'b1 && c < 40);
      chk(c[15:0], n[15:0]);
      chk(fetch_data, d);
      // release on the edge that sees done; busy covers that edge
      @(posedge sys_clk);
      fetch_req <= 1'b0;
   endtask
   task automatic xmove(input logic wr, input logic via, input logic [15:0] a,
         input logic [7:0] d, input int n);
      int c;
      @(posedge sys_clk);
      xmove_req <= 1'b1;
      xmove_wr <= wr;
      xmove_via_pointer <= via;
      data_pointer <= via ? a : ~a;
      {port_two_page, xmove_reg} <= via ? ~a : a;
      accumulator <= d;
      c = 0;
      do begin
         @(posedge sys_clk);
         #1 c++;
      end while (xmove_done !== 1'b1 && c < 40);
      chk(c[15:0], n[15:0]);
      if (n == 1) begin
         chk({xdata_rd, xdata_wr, xdata_wdata}, {!wr, wr, d});
         chk(xdata_addr, a);
      end
      // release on the edge that sees done; the design ignores that edge
      @(posedge sys_clk);
      xmove_req <= 1'b0;
   endtask
   task automatic ram_rt(input imem_pkg::access_kind_t k, input logic [7:0] a,
         input imem_pkg::region_t r);
      acc(1'b1, k, a, a ^ 8'h3C);
      acc(1'b0, k, a, 8'h00);
      chk(rd_q, a ^ 8'h3C);
      chk_reg(mem_region, r);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_local_regs();
      acc(1'b0, imem_pkg::KIND_DIRECT, 8'h87, 8'h00);
      chk(rd_q, 8'h00);
      acc(1'b0, imem_pkg::KIND_DIRECT, 8'h92, 8'h00);
      chk({rd_q, code_wait_select}, {8'h07, 3'h7});
      acc(1'b1, imem_pkg::KIND_DIRECT, 8'h87, 8'h98);
      acc(1'b0, imem_pkg::KIND_DIRECT, 8'h87, 8'h00);
      chk({rd_q, program_write_enable, s_rd}, {8'h90, 2'h2});
      acc(1'b1, imem_pkg::KIND_DIRECT, 8'h92, 8'hFB);
      acc(1'b0, imem_pkg::KIND_DIRECT, 8'h92, 8'h00);
      chk(rd_q, 8'h03);
   endtask
   task automatic t_regions();
      ram_rt(imem_pkg::KIND_DIRECT, 8'h00, imem_pkg::REGION_BANK);
      ram_rt(imem_pkg::KIND_DIRECT, 8'h1F, imem_pkg::REGION_BANK);
      ram_rt(imem_pkg::KIND_DIRECT, 8'h20, imem_pkg::REGION_BIT_AREA);
      ram_rt(imem_pkg::KIND_DIRECT, 8'h2F, imem_pkg::REGION_BIT_AREA);
      ram_rt(imem_pkg::KIND_DIRECT, 8'h30, imem_pkg::REGION_SCRATCH);
      ram_rt(imem_pkg::KIND_INDIRECT, 8'h7F, imem_pkg::REGION_SCRATCH);
      ram_rt(imem_pkg::KIND_INDIRECT, 8'h80, imem_pkg::REGION_UPPER_RAM);
      ram_rt(imem_pkg::KIND_INDIRECT, 8'hFF, imem_pkg::REGION_UPPER_RAM);
      acc(1'b1, imem_pkg::KIND_DIRECT, 8'h80, 8'h11);
      chk({s_rd, s_wr, s_a}, {2'h3, 8'h80});
      acc(1'b0, imem_pkg::KIND_INDIRECT, 8'h80, 8'h00);
      chk(rd_q, 8'hBC);
      acc(1'b0, imem_pkg::KIND_DIRECT, 8'hA0, 8'h00);
      chk(rd_q, 8'hFA);
   endtask
   task automatic t_bits();
      @(posedge sys_clk);
      mem_bank <= 2'h2;
      acc(1'b1, imem_pkg::KIND_REGISTER, 8'h03, 8'h77);
      acc(1'b0, imem_pkg::KIND_DIRECT, 8'h13, 8'h00);
      chk(rd_q, 8'h77);
      acc(1'b1, imem_pkg::KIND_DIRECT, 8'h21, 8'h00);
      acc(1'b1, imem_pkg::KIND_BIT, 8'h0A, 8'h01);
      acc(1'b0, imem_pkg::KIND_DIRECT, 8'h21, 8'h00);
      chk(rd_q, 8'h04);
      acc(1'b1, imem_pkg::KIND_BIT, 8'hA3, 8'h00);
      chk({s_wr, s_a, s_wd}, {1'b1, 8'hA0, 8'hF2});
   endtask
   task automatic t_code();
      logic [2:0] ws [4] = '{3'h7, 3'h3, 3'h5, 3'h1};
      foreach (ws[i]) begin
         acc(1'b1, imem_pkg::KIND_DIRECT, 8'h92, {5'h00, ws[i]});
         fetch(16'h0123, 8'h22, (ws[i] < 3'h3 ? 3 : ws[i]) + 2);
      end
      acc(1'b1, imem_pkg::KIND_DIRECT, 8'h92, 8'h07);
      @(posedge sys_clk);
      data_wait_control <= 3'h1;
      xmove(1'b1, 1'b1, 16'h1234, 8'hA5, 3);
      @(posedge sys_clk);
      data_wait_control <= 3'h0;
      xmove(1'b1, 1'b0, 16'h5678, 8'h3C, 2);
      fetch(16'h1234, 8'hA5, 9);
      fetch(16'h5678, 8'h3C, 9);
      // reads go to data memory even with program write enabled
      xmove(1'b0, 1'b1, 16'h2345, 8'h66, 1);
      acc(1'b1, imem_pkg::KIND_DIRECT, 8'h87, 8'h00);
      xmove(1'b1, 1'b1, 16'h1234, 8'h11, 1);
      fetch(16'h1234, 8'hA5, 9);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (6000) @(posedge sys_clk);
      err_count++;
      test_done();
   end
   initial begin
      {rst_n, mem_req, mem_wr, fetch_req, xmove_req, xmove_wr} = 6'h00;
      {xmove_via_pointer, mem_bank, data_wait_control} = 6'h00;
      {mem_addr, mem_wdata, xmove_reg, port_two_page, accumulator} = 40'h0;
      {fetch_addr, data_pointer} = 32'h0000_0000;
      mem_kind = imem_pkg::KIND_DIRECT;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_local_regs();
      t_regions();
      t_bits();
      t_code();
      test_done();
   end
endmodule

//--- verilog/code_access_engine.sv
// code memory access engine: timed read and write strobes
// assumes: code memory answers on the same clock, data valid by last cycle
`timescale 1ns/1ps
`include "imem_defs.svh"

module code_access_engine (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control from the decoder
   code_ctl_if.engine ctl,
   // code memory array
   output logic [15:0] code_addr,
   output logic code_rd,
   output logic code_wr,
   output logic [7:0] code_wdata,
   input wire logic [7:0] code_rdata
);
   imem_pkg::engine_state_t state_q, state_d;
   logic [`CNT_W-1:0] cnt_q, cnt_d;
   logic [15:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d;
   logic [7:0] rdata_q, rdata_d;
   logic done_q, done_d;
   logic [2:0] rwait;

   // ----------------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      done_d = 1'b0;
      rwait = (ctl.read_wait < `CODE_WAIT_MIN) ? `CODE_WAIT_MIN
                                                : ctl.read_wait;
      case (state_q)
         imem_pkg::ENG_IDLE: begin
            if (ctl.start_rd) begin
               state_d = imem_pkg::ENG_READ;
               cnt_d = {1'b0, rwait};
               addr_d = ctl.addr;
            end else if (ctl.start_wr) begin
               state_d = imem_pkg::ENG_WRITE;
               cnt_d = {1'b0, ctl.write_wait};
               addr_d = ctl.addr;
               wdata_d = ctl.wdata;
            end
         end
         imem_pkg::ENG_READ: begin
            if (cnt_q == '0) begin
               rdata_d = code_rdata;
               done_d = 1'b1;
               state_d = imem_pkg::ENG_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         imem_pkg::ENG_WRITE: begin
            if (cnt_q == '0) begin
               done_d = 1'b1;
               state_d = imem_pkg::ENG_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            state_d = imem_pkg::ENG_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= imem_pkg::ENG_IDLE;
         cnt_q <= '0;
         addr_q <= 16'h0000;
         wdata_q <= 8'h00;
         rdata_q <= 8'h00;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
      end
   end

   // address held while strobe is up
   assign code_addr = addr_q;
   assign code_rd = (state_q == imem_pkg::ENG_READ);
   assign code_wr = (state_q == imem_pkg::ENG_WRITE);
   assign code_wdata = wdata_q;
   // done cycle counts as busy so a held request is not restarted
   assign ctl.busy = (state_q != imem_pkg::ENG_IDLE) || done_q;
   assign ctl.done = done_q;
   assign ctl.rdata = rdata_q;
endmodule

//--- verilog/code_ctl_if.sv
// carrier between the decoder top and the code memory access engine
// assumes: both ends run on the same system clock
`timescale 1ns/1ps
interface code_ctl_if;
   logic start_rd;
   logic start_wr;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [2:0] read_wait;
   logic [2:0] write_wait;
   logic busy;
   logic done;
   logic [7:0] rdata;

   modport ctrl (
      output start_rd,
      output start_wr,
      output addr,
      output wdata,
      output read_wait,
      output write_wait,
      input busy,
      input done,
      input rdata
   );

   modport engine (
      input start_rd,
      input start_wr,
      input addr,
      input wdata,
      input read_wait,
      input write_wait,
      output busy,
      output done,
      output rdata
   );
endinterface

//--- verilog/imem_defs.svh
// constants for the internal data space decoder and code memory access
// assumes: included by bare name from the design modules
`ifndef IMEM_DEFS_SVH
`define IMEM_DEFS_SVH

// ----------------------------------------------------------------------
// internal data space layout
// ----------------------------------------------------------------------
`define BANK_BASE 8'h00
`define BANK_TOP 8'h1F
`define BIT_AREA_BASE 8'h20
`define BIT_AREA_TOP 8'h2F
`define SCRATCH_BASE 8'h30
`define SCRATCH_TOP 8'h7F
`define UPPER_BASE 8'h80
`define UPPER_TOP 8'hFF
`define RAM_DEPTH 256

// ----------------------------------------------------------------------
// special function registers kept in this block
// ----------------------------------------------------------------------
`define POWER_CONTROL_ADDR 8'h87
`define POWER_CONTROL_RESET 8'h00
`define PROG_WR_BIT 4
`define HI_FLAG_BIT 7
`define CODE_WAIT_ADDR 8'h92
`define CODE_WAIT_RESET 3'h7
`define CODE_WAIT_MIN 3'h3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CNT_W 4
`endif

//--- verilog/imem_pkg.sv
// types shared by the data space decoder and the code access engine
// assumes: imem_defs.svh sits on the include path
package imem_pkg;
   // where an internal data space access lands
   typedef enum logic [2:0] {
      REGION_BANK,
      REGION_BIT_AREA,
      REGION_SCRATCH,
      REGION_UPPER_RAM,
      REGION_SFR
   } region_t;

   // how the core addresses the internal data space
   typedef enum logic [1:0] {
      KIND_DIRECT,
      KIND_INDIRECT,
      KIND_REGISTER,
      KIND_BIT
   } access_kind_t;

   // code access engine states
   typedef enum logic [1:0] {
      ENG_IDLE,
      ENG_READ,
      ENG_WRITE
   } engine_state_t;
endpackage

//--- verilog/internal_memory_and_code_access.sv
// internal data space decoder with 256-byte RAM, local special function
// registers and code memory fetch / write control
// assumes: one 40 MHz clock; core holds each request until its done pulse;
// outside special function registers answer sfr_rdata in the same cycle
`timescale 1ns/1ps
`include "imem_defs.svh"

module internal_memory_and_code_access (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // internal data space access from the core
   input wire logic mem_req,
   input wire logic mem_wr,
   input wire imem_pkg::access_kind_t mem_kind,
   input wire logic [7:0] mem_addr,
   input wire logic [1:0] mem_bank,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   output logic mem_ack,
   output imem_pkg::region_t mem_region,
   // special function registers outside this block
   output logic sfr_rd,
   output logic sfr_wr,
   output logic [7:0] sfr_addr,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // instruction fetch and code-move reads
   input wire logic fetch_req,
   input wire logic [15:0] fetch_addr,
   output logic [7:0] fetch_data,
   output logic fetch_done,
   // external move instruction
   input wire logic xmove_req,
   input wire logic xmove_wr,
   input wire logic xmove_via_pointer,
   input wire logic [15:0] data_pointer,
   input wire logic [7:0] xmove_reg,
   input wire logic [7:0] port_two_page,
   input wire logic [7:0] accumulator,
   input wire logic [2:0] data_wait_control,
   output logic xmove_done,
   // data memory side of external moves
   output logic xdata_rd,
   output logic xdata_wr,
   output logic [15:0] xdata_addr,
   output logic [7:0] xdata_wdata,
   // code memory array
   output logic [15:0] code_addr,
   output logic code_rd,
   output logic code_wr,
   output logic [7:0] code_wdata,
   input wire logic [7:0] code_rdata,
   // status
   output logic program_write_enable,
   output logic [2:0] code_wait_select
);
   // ----------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------
   function automatic imem_pkg::region_t decode_region(
      input logic [7:0] a, input logic indirect);
      imem_pkg::region_t r;
      r = imem_pkg::REGION_SCRATCH;
      if (a <= `BANK_TOP)
         r = imem_pkg::REGION_BANK;
      else if (a <= `BIT_AREA_TOP)
         r = imem_pkg::REGION_BIT_AREA;
      else if (a <= `SCRATCH_TOP)
         r = imem_pkg::REGION_SCRATCH;
      else if (indirect)
         r = imem_pkg::REGION_UPPER_RAM;
      else
         r = imem_pkg::REGION_SFR;
      return r;
   endfunction

   // byte holding a bit address
   function automatic logic [7:0] bit_byte(input logic [7:0] b);
      logic [7:0] r;
      // only 0 or 8 low nibble registers
      if (b[7])
         r = {b[7:3], 3'b000};
      else
         r = `BIT_AREA_BASE + {4'h0, b[6:3]};
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic [7:0] ram_q [0:`RAM_DEPTH-1];
   logic ram_we;
   logic [7:0] ram_wdata;
   logic prog_wr_q, prog_wr_d;
   logic hi_flag_q, hi_flag_d;
   logic [2:0] wait_q, wait_d;
   logic [7:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   imem_pkg::region_t region_q, region_d;
   logic xdone_q, xdone_d;
   logic xrd_q, xrd_d;
   logic xwr_q, xwr_d;
   logic [15:0] xaddr_q, xaddr_d;
   logic [7:0] xwdata_q, xwdata_d;

   logic [7:0] ea;
   imem_pkg::region_t region;
   logic in_ram;
   logic hit_power;
   logic hit_wait;
   logic [7:0] cur_byte;
   logic [7:0] new_byte;
   logic [7:0] local_rd;
   logic [15:0] xmove_addr;
   logic code_write_go;
   logic data_move_go;

   code_ctl_if ctl ();

   // ----------------------------------------------------------------------
   // internal data space access
   // ----------------------------------------------------------------------
   always_comb begin
      case (mem_kind)
         imem_pkg::KIND_REGISTER: ea = {3'b000, mem_bank, mem_addr[2:0]};
         imem_pkg::KIND_BIT: ea = bit_byte(mem_addr);
         default: ea = mem_addr;
      endcase
   end

   assign region = decode_region(ea, mem_kind == imem_pkg::KIND_INDIRECT);
   assign in_ram = (region != imem_pkg::REGION_SFR);
   assign hit_power = !in_ram && (ea == `POWER_CONTROL_ADDR);
   assign hit_wait = !in_ram && (ea == `CODE_WAIT_ADDR);

   always_comb begin
      local_rd = 8'h00;
      if (hit_power) begin
         local_rd[`HI_FLAG_BIT] = hi_flag_q;
         local_rd[`PROG_WR_BIT] = prog_wr_q;
      end else if (hit_wait) begin
         local_rd = {5'b0_0000, wait_q};
      end
   end

   always_comb begin
      if (in_ram)
         cur_byte = ram_q[ea];
      else if (hit_power || hit_wait)
         cur_byte = local_rd;
      else
         cur_byte = sfr_rdata;
      // bit writes are read-modify-write of the holding byte
      new_byte = mem_wdata;
      if (mem_kind == imem_pkg::KIND_BIT) begin
         new_byte = cur_byte;
         new_byte[mem_addr[2:0]] = mem_wdata[0];
      end
   end

   // outside registers see the cycle of the request itself
   assign sfr_addr = ea;
   assign sfr_rd = mem_req && !in_ram && !hit_power && !hit_wait;
   assign sfr_wr = sfr_rd && mem_wr;
   assign sfr_wdata = new_byte;
   assign ram_we = mem_req && mem_wr && in_ram;
   assign ram_wdata = new_byte;

   // ----------------------------------------------------------------------
   // local registers and answer
   // ----------------------------------------------------------------------
   always_comb begin
      prog_wr_d = prog_wr_q;
      hi_flag_d = hi_flag_q;
      wait_d = wait_q;
      rdata_d = rdata_q;
      ack_d = 1'b0;
      region_d = region_q;
      if (mem_req) begin
         ack_d = 1'b1;
         region_d = region;
         rdata_d = cur_byte;
         if (mem_wr && hit_power) begin
            prog_wr_d = new_byte[`PROG_WR_BIT];
            hi_flag_d = new_byte[`HI_FLAG_BIT];
         end
         if (mem_wr && hit_wait)
            wait_d = new_byte[2:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_wr_q <= 1'(`POWER_CONTROL_RESET >> `PROG_WR_BIT);
         hi_flag_q <= 1'(`POWER_CONTROL_RESET >> `HI_FLAG_BIT);
         wait_q <= `CODE_WAIT_RESET;
         rdata_q <= 8'h00;
         ack_q <= 1'b0;
         region_q <= imem_pkg::REGION_BANK;
      end else begin
         prog_wr_q <= prog_wr_d;
         hi_flag_q <= hi_flag_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         region_q <= region_d;
      end
   end

   // the RAM carries no reset, its contents are undefined at power-up
   always_ff @(posedge sys_clk) begin
      if (ram_we)
         ram_q[ea] <= ram_wdata;
   end

   // ----------------------------------------------------------------------
   // code memory requests
   // ----------------------------------------------------------------------
   // pointer or port-two page with register
   assign xmove_addr = xmove_via_pointer ? data_pointer
                                         : {port_two_page, xmove_reg};
   assign code_write_go = xmove_req && xmove_wr && prog_wr_q && !fetch_req &&
                          !ctl.busy;
   // ordinary data moves when not writing code
   assign data_move_go = xmove_req && !(xmove_wr && prog_wr_q) && !xdone_q;

   // fetch wins a tie; a waiting external move is held by the core
   assign ctl.start_rd = fetch_req && !ctl.busy;
   assign ctl.start_wr = code_write_go;
   assign ctl.addr = fetch_req ? fetch_addr : xmove_addr;
   assign ctl.wdata = accumulator;
   assign ctl.read_wait = wait_q;
   assign ctl.write_wait = data_wait_control;

   always_comb begin
      xdone_d = 1'b0;
      xrd_d = 1'b0;
      xwr_d = 1'b0;
      xaddr_d = xaddr_q;
      xwdata_d = xwdata_q;
      if (data_move_go) begin
         xdone_d = 1'b1;
         xrd_d = !xmove_wr;
         xwr_d = xmove_wr;
         xaddr_d = xmove_addr;
         xwdata_d = accumulator;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         xdone_q <= 1'b0;
         xrd_q <= 1'b0;
         xwr_q <= 1'b0;
         xaddr_q <= 16'h0000;
         xwdata_q <= 8'h00;
      end else begin
         xdone_q <= xdone_d;
         xrd_q <= xrd_d;
         xwr_q <= xwr_d;
         xaddr_q <= xaddr_d;
         xwdata_q <= xwdata_d;
      end
   end

   code_access_engine u_engine (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ctl(ctl.engine),
      .code_addr(code_addr),
      .code_rd(code_rd),
      .code_wr(code_wr),
      .code_wdata(code_wdata),
      .code_rdata(code_rdata)
   );

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign mem_rdata = rdata_q;
   assign mem_ack = ack_q;
   assign mem_region = region_q;
   // a done pulse ends the fetch whenever fetch_req is up, otherwise the external move
   assign fetch_data = ctl.rdata;
   assign fetch_done = ctl.done && fetch_req;
   assign xmove_done = xdone_q || (ctl.done && !fetch_req && xmove_req);
   assign xdata_rd = xrd_q;
   assign xdata_wr = xwr_q;
   assign xdata_addr = xaddr_q;
   assign xdata_wdata = xwdata_q;
   assign program_write_enable = prog_wr_q;
   assign code_wait_select = wait_q;
endmodule
